// ===== hdl/srhp_device.sv
/*
 Device end: shared 16K x 8 memory with arbitration between the
 internal processor port and the host strobe port.
 Assumes host pins arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`include "srhp_defines.svh"
module srhp_device
   import srhp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   srhp_if.device          port,
   input  wire logic       intReq,
   input  wire srhp_addr_t intAddr,
   input  wire logic       intWrite,
   input  wire srhp_data_t intWdata,
   output      srhp_data_t intRdata,
   output      logic       intGrant,
   input  wire logic       intrEvent,
   input  wire logic       intrEnable,
   input  wire logic       hwError,
   input  wire logic       linkBusy,
   output      logic       handheldSeen,
   output      logic       coreResetN
);
   // ****************************************
   // Synchronisers
   // ****************************************
   logic [2:0]  ctlMeta_reg;
   logic [2:0]  ctlSync_reg;
   logic [1:0]  auxMeta_reg;
   logic [1:0]  auxSync_reg;
   srhp_addr_t  addrMeta_reg;
   srhp_addr_t  addrSync_reg;
   srhp_data_t  dataMeta_reg;
   srhp_data_t  dataSync_reg;
   logic        selN;
   logic        wrN;
   logic        rdN;

   // Two stages on every host pin; first stage read only by second
   always_ff @(posedge clk) begin
      ctlMeta_reg  <= {port.hostSelectN, port.writeN, port.readN};
      ctlSync_reg  <= ctlMeta_reg;
      auxMeta_reg  <= {port.hostResetN, port.handheldPresent};
      auxSync_reg  <= auxMeta_reg;
      addrMeta_reg <= port.addr;
      addrSync_reg <= addrMeta_reg;
      dataMeta_reg <= port.dataBus;
      dataSync_reg <= dataMeta_reg;
   end
   assign selN = ctlSync_reg[2];
   assign wrN  = ctlSync_reg[1];
   assign rdN  = ctlSync_reg[0];

   // ****************************************
   // Reset and presence
   // ****************************************
   logic rstN;
   assign rstN         = resetn & auxSync_reg[1];
   assign coreResetN   = rstN;
   assign handheldSeen = auxSync_reg[0];

   // ****************************************
   // Decode helpers
   // ****************************************
   // One place decides what counts as a live host request
   function automatic logic hostStrobe(
      input logic sel,
      input logic wr,
      input logic rd
   );
      return ~sel & (~wr | ~rd);
   endfunction

   // ****************************************
   // Shared memory and arbitration
   // ****************************************
   srhp_data_t      mem [0:`SRHP_DEPTH-1];
   srhp_dev_state_t state_reg;
   srhp_data_t      readData_reg;
   srhp_data_t      intRdata_reg;
   logic [2:0]      intCnt_reg;
   logic            intBusy;
   logic            hostReq;
   logic            inReady;

   // Request, busy and ready decodes shared by the processes below
   assign hostReq = hostStrobe(selN, wrN, rdN);
   assign intBusy = intCnt_reg != 3'h0;
   assign inReady = state_reg == SRHP_READY;

   // Internal holder keeps memory for a fixed slot
   always_ff @(posedge clk) begin
      if (!rstN) begin
         intCnt_reg <= 3'h0;
      end else if (intBusy) begin
         intCnt_reg <= intCnt_reg - 3'h1;
      end else if (intReq && state_reg == SRHP_IDLE && !hostReq) begin
         intCnt_reg <= `SRHP_INTERNAL_LEN;
      end
   end
   assign intGrant = intBusy;

   // Host cycle: wait for internal slot, access, hold ready
   always_ff @(posedge clk) begin
      if (!rstN) begin
         state_reg <= SRHP_IDLE;
      end else begin
         case (state_reg)
            SRHP_IDLE: begin
               if (hostReq) begin
                  state_reg <= SRHP_WAIT;
               end
            end
            SRHP_WAIT: begin
               if (!intBusy) begin
                  state_reg <= SRHP_READY;
               end
            end
            SRHP_READY: begin
               // Stay until the host drops its strobes, else a reread
               if (!hostStrobe(selN, wrN, rdN)) begin
                  state_reg <= SRHP_IDLE;
               end
            end
            default: state_reg <= SRHP_IDLE;
         endcase
      end
   end

   // Memory access ports; host takes the slot once granted
   // One port per cycle, so the array never sees two writers
   always_ff @(posedge clk) begin
      if (state_reg == SRHP_WAIT && !intBusy) begin
         if (!wrN) begin
            mem[addrSync_reg] <= dataSync_reg;
         end
         readData_reg <= mem[addrSync_reg];
      end else if (intBusy && intCnt_reg == `SRHP_INTERNAL_LEN) begin
         if (intWrite) begin
            mem[intAddr] <= intWdata;
         end
         intRdata_reg <= mem[intAddr];
      end
   end
   assign intRdata = intRdata_reg;

   // Outputs to host; ready released when deselected
   assign port.devDataOut   = readData_reg;
   assign port.devDataOe    = inReady & ~rdN & ~selN;
   assign port.cycleReadyN  = ~inReady;
   assign port.cycleReadyOe = ~selN;

   // ****************************************
   // Interrupt strobe
   // ****************************************
   logic [3:0] intrCnt_reg;
   // A new enabled event restarts the pulse at full length
   always_ff @(posedge clk) begin
      if (!rstN) begin
         intrCnt_reg <= 4'h0;
      end else if (intrEvent && intrEnable) begin
         intrCnt_reg <= `SRHP_INT_PULSE;
      end else if (intrCnt_reg != 4'h0) begin
         intrCnt_reg <= intrCnt_reg - 4'h1;
      end
   end
   assign port.intrOe = intrCnt_reg != 4'h0;

   // ****************************************
   // Status outputs
   // ****************************************
   logic fault_reg;
   logic linkN_reg;
   // Fault is sticky until reset so a glitch is not missed
   always_ff @(posedge clk) begin
      if (!rstN) begin
         fault_reg <= 1'b0;
      end else if (hwError) begin
         fault_reg <= 1'b1;
      end
   end
   // Link status registered so the pin never glitches
   always_ff @(posedge clk) begin
      if (!rstN) begin
         linkN_reg <= 1'b1;
      end else begin
         linkN_reg <= ~linkBusy;
      end
   end
   assign port.boardFaultOut = fault_reg;
   assign port.linkActiveN   = linkN_reg;
endmodule // srhp_device

// ===== hdl/srhp_defines.svh
/*
 Timing counts and widths for the shared memory host port.
 Assumes a 20 MHz clock on both ends.
*/
`ifndef SRHP_DEFINES_SVH
`define SRHP_DEFINES_SVH
`define SRHP_ADDR_W        14
`define SRHP_DATA_W        8
`define SRHP_DEPTH         16384
`define SRHP_CLK_HZ        20000000
`define SRHP_RESET_HOLD_MS 20
`define SRHP_RESET_CYCLES  ((`SRHP_CLK_HZ / 1000) * `SRHP_RESET_HOLD_MS)
`define SRHP_INT_PULSE     4'h4
`define SRHP_INTERNAL_LEN  3'h3
`endif

// ===== hdl/srhp_pkg.sv
/*
 Types shared by both ends of the shared memory host port.
 Assumes the defines header is compiled alongside.
*/
`include "srhp_defines.svh"
package srhp_pkg;
   typedef logic [`SRHP_ADDR_W-1:0] srhp_addr_t;
   typedef logic [`SRHP_DATA_W-1:0] srhp_data_t;
   typedef enum logic [1:0] {
      SRHP_IDLE,
      SRHP_WAIT,
      SRHP_READY
   } srhp_dev_state_t;
   typedef enum logic [1:0] {
      SRHP_H_IDLE,
      SRHP_H_STROBE,
      SRHP_H_END
   } srhp_host_state_t;
endpackage

// ===== hdl/srhp_if.sv
/*
 Wires between host and device end of the shared memory port.
 Resolves the data bus and open-drain lines from the enables.
*/
`timescale 1ns/1ps
interface srhp_if;
   import srhp_pkg::*;
   srhp_addr_t addr;
   logic       hostSelectN;
   logic       writeN;
   logic       readN;
   srhp_data_t hostDataOut;
   logic       hostDataOe;
   srhp_data_t devDataOut;
   logic       devDataOe;
   srhp_data_t dataBus;
   logic       cycleReadyN;
   logic       cycleReadyOe;
   logic       readyLine;
   logic       intrOe;
   logic       intrLineN;
   logic       hostResetN;
   logic       handheldPresent;
   logic       boardFaultOut;
   logic       linkActiveN;
   // Released lines read as pulled high
   assign dataBus   = devDataOe ? devDataOut :
                      (hostDataOe ? hostDataOut : 8'hFF);
   assign readyLine = cycleReadyOe ? cycleReadyN : 1'b1;
   assign intrLineN = intrOe ? 1'b0 : 1'b1;
   modport device (
      input  addr, hostSelectN, writeN, readN, dataBus, hostResetN,
      input  handheldPresent,
      output devDataOut, devDataOe, cycleReadyN, cycleReadyOe, intrOe,
      output boardFaultOut, linkActiveN
   );
   modport host (
      output addr, hostSelectN, writeN, readN, hostDataOut, hostDataOe,
      output hostResetN, handheldPresent,
      input  dataBus, readyLine, intrLineN, boardFaultOut, linkActiveN
   );
endinterface // srhp_if

// ===== hdl/srhp_host.sv
/*
 Host end: turns single read/write requests into strobed cycles
 and holds each cycle open until ready. Holds device reset after
 its own reset for the power-up time.
 Assumes device lines arrive asynchronously.
*/
`timescale 1ns/1ps
`include "srhp_defines.svh"
module srhp_host
   import srhp_pkg::*;
#(
   parameter int RESET_CYCLES = `SRHP_RESET_CYCLES
)
(
   input  wire logic       clk,
   input  wire logic       resetn,
   srhp_if.host            port,
   input  wire logic       reqValid,
   input  wire logic       reqWrite,
   input  wire srhp_addr_t reqAddr,
   input  wire srhp_data_t reqWdata,
   input  wire logic       monitorAttached,
   output      logic       reqReady,
   output      logic       rspValid,
   output      srhp_data_t rspData,
   output      logic       intrSeen,
   output      logic       deviceFault,
   output      logic       deviceLinkActive
);
   // ****************************************
   // Synchronisers
   // ****************************************
   logic [3:0] meta_reg;
   logic [3:0] sync_reg;
   logic       intrPrev_reg;
   always_ff @(posedge clk) begin
      meta_reg <= {port.readyLine, port.intrLineN, port.boardFaultOut,
                   port.linkActiveN};
      sync_reg <= meta_reg;
   end
   always_ff @(posedge clk) begin
      intrPrev_reg <= sync_reg[2];
   end
   assign intrSeen         = intrPrev_reg & ~sync_reg[2];
   assign deviceFault      = sync_reg[1];
   assign deviceLinkActive = ~sync_reg[0];

   // ****************************************
   // Power-up reset hold
   // ****************************************
   logic [31:0] rstCnt_reg;
   logic        devRstN_reg;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rstCnt_reg  <= 32'h0;
         devRstN_reg <= 1'b0;
      end else if (rstCnt_reg < 32'(RESET_CYCLES)) begin
         rstCnt_reg  <= rstCnt_reg + 32'h1;
      end else begin
         devRstN_reg <= 1'b1;
      end
   end
   assign port.hostResetN      = devRstN_reg;
   assign port.handheldPresent = monitorAttached;

   // ****************************************
   // Cycle engine
   // ****************************************
   srhp_host_state_t state_reg;
   srhp_addr_t       addr_reg;
   srhp_data_t       wdata_reg;
   logic             write_reg;
   srhp_data_t       rdata_reg;
   logic             rspValid_reg;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg    <= SRHP_H_IDLE;
         addr_reg     <= 14'h0000;
         wdata_reg    <= 8'h00;
         write_reg    <= 1'b0;
         rdata_reg    <= 8'h00;
         rspValid_reg <= 1'b0;
      end else begin
         rspValid_reg <= 1'b0;
         case (state_reg)
            SRHP_H_IDLE: begin
               if (reqValid && devRstN_reg) begin
                  addr_reg  <= reqAddr;
                  wdata_reg <= reqWdata;
                  write_reg <= reqWrite;
                  state_reg <= SRHP_H_STROBE;
               end
            end
            SRHP_H_STROBE: begin
               // Cycle stays open until ready seen
               if (!sync_reg[3]) begin
                  rdata_reg    <= port.dataBus;
                  rspValid_reg <= 1'b1;
                  state_reg    <= SRHP_H_END;
               end
            end
            SRHP_H_END: begin
               // Wait for ready release before next cycle
               if (sync_reg[3]) begin
                  state_reg <= SRHP_H_IDLE;
               end
            end
            default: state_reg <= SRHP_H_IDLE;
         endcase
      end
   end
   assign reqReady = (state_reg == SRHP_H_IDLE) & devRstN_reg;
   assign rspValid = rspValid_reg;
   assign rspData  = rdata_reg;

   // Data valid for the whole write strobe
   assign port.addr        = addr_reg;
   assign port.hostSelectN = ~(state_reg == SRHP_H_STROBE);
   assign port.writeN      = ~(state_reg == SRHP_H_STROBE && write_reg);
   assign port.readN       = ~(state_reg == SRHP_H_STROBE && !write_reg);
   assign port.hostDataOut = wdata_reg;
   assign port.hostDataOe  = state_reg == SRHP_H_STROBE && write_reg;
endmodule // srhp_host

// ===== testbench/srhp_assertions.sv
/*
 Concurrent checks on the wires between host and device ends.
 Assumes instantiation beside the interface, on the bench clock.
*/
`timescale 1ns/1ps
module srhp_assertions
   import srhp_pkg::*;
(
   input wire logic       clk,
   input wire logic       resetn,
   input wire srhp_addr_t addr,
   input wire logic       hostSelectN,
   input wire logic       writeN,
   input wire logic       readN,
   input wire logic       devDataOe,
   input wire logic       cycleReadyN,
   input wire logic       cycleReadyOe,
   input wire logic       intrOe,
   input wire logic       boardFaultOut,
   input wire logic       hostResetN
);
   // ***************************************
   // Wire protocol properties
   // ***************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // Device sees host pins through two flops, so look two cycles back
   a_drive_on_read: assert property (devDataOe |->
      !$past(readN, 2) && !$past(hostSelectN, 2))
      else $error("data driven outside a read");
   a_read_data_out: assert property (!readN && !hostSelectN && cycleReadyOe
      && !cycleReadyN |-> devDataOe) else $error("ready read without data");
   a_ready_needs_sel: assert property (cycleReadyOe |->
      !$past(hostSelectN, 2)) else $error("ready driven while unselected");
   a_cycle_held_open: assert property (!hostSelectN &&
      !(cycleReadyOe && !cycleReadyN) |=> !hostSelectN)
      else $error("cycle dropped before ready");
   // Bound covers one internal access ahead of the host
   a_ready_in_time: assert property ($fell(hostSelectN) |->
      ##[2:40] (cycleReadyOe && !cycleReadyN)) else $error("ready late");
   a_intr_pulse_len: assert property ($rose(intrOe) |->
      intrOe [*4] ##1 !intrOe) else $error("interrupt pulse length");
   a_fault_sticky: assert property (disable iff (!resetn || !hostResetN)
      boardFaultOut |=> boardFaultOut) else $error("fault flag cleared");
   a_one_strobe: assert property (readN || writeN)
      else $error("both strobes low");
   a_strobe_has_sel: assert property (!readN || !writeN |-> !hostSelectN)
      else $error("strobe without select");
   a_addr_stable: assert property (!hostSelectN && !$past(hostSelectN)
      |-> $stable(addr)) else $error("address moved in cycle");
   a_reset_quiet: assert property (!hostResetN [*3] |-> !devDataOe &&
      !cycleReadyOe && !intrOe) else $error("device active in reset");
endmodule // srhp_assertions

// ===== testbench/test_shared_ram_host_port.sv
/*
 Self-checking bench joining host and device ends by the interface.
 Assumes design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_shared_ram_host_port
   import srhp_pkg::*;
;
   logic       clk = 0, resetn = 0, reqValid = 0, reqWrite = 0;
   logic       intReq = 0, intWrite = 0, intrEvent = 0, intrEnable = 0;
   logic       hwError = 0, linkBusy = 0, monitorAttached = 0;
   srhp_addr_t reqAddr = '0, intAddr = '0;
   srhp_data_t reqWdata = '0, intWdata = '0, rspData, intRdata;
   logic       reqReady, rspValid, intrSeen, deviceFault, deviceLinkActive;
   logic       intGrant, handheldSeen, coreResetN;
   int         fails = 0, numChecks = 0, cycles = 0, intrCount = 0;
   int         mem[int];
   srhp_if bus ();
   srhp_device srhp_device_i (.clk(clk), .resetn(resetn), .port(bus.device),
      .intReq(intReq), .intAddr(intAddr), .intWrite(intWrite),
      .intWdata(intWdata), .intRdata(intRdata), .intGrant(intGrant),
      .intrEvent(intrEvent), .intrEnable(intrEnable), .hwError(hwError),
      .linkBusy(linkBusy), .handheldSeen(handheldSeen),
      .coreResetN(coreResetN));
   // Short power-up hold keeps the run brief
   srhp_host #(.RESET_CYCLES(20)) srhp_host_i (.clk(clk), .resetn(resetn),
      .port(bus.host), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqWdata(reqWdata),
      .monitorAttached(monitorAttached), .reqReady(reqReady),
      .rspValid(rspValid), .rspData(rspData), .intrSeen(intrSeen),
      .deviceFault(deviceFault), .deviceLinkActive(deviceLinkActive));
   srhp_assertions chk (.clk(clk), .resetn(resetn), .addr(bus.addr),
      .hostSelectN(bus.hostSelectN), .writeN(bus.writeN), .readN(bus.readN),
      .devDataOe(bus.devDataOe), .cycleReadyN(bus.cycleReadyN),
      .cycleReadyOe(bus.cycleReadyOe), .intrOe(bus.intrOe),
      .boardFaultOut(bus.boardFaultOut), .hostResetN(bus.hostResetN));
   // ***************************************
   // Clock, watchdog and tasks
   // ***************************************
   always #25 clk = ~clk;
   // Cycle ceiling far above the expected run
   always @(posedge clk) begin
      cycles++;
      if (intrSeen === 1'b1) intrCount++;
      if (cycles == 5000) begin
         fails++;
         printVerdict();
      end
   end
   task printVerdict;
      if (fails == 0 && numChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One host cycle; request held until taken
   task hostOp(input logic w, input srhp_addr_t a, input srhp_data_t d);
      int n;
      n = 0;
      reqValid <= 1'b1; reqWrite <= w; reqAddr <= a; reqWdata <= d;
      do @(posedge clk); while (reqReady !== 1'b1 && ++n < 500);
      reqValid <= 1'b0;
      do @(posedge clk); while (rspValid !== 1'b1 && ++n < 500);
      `CHK("rspValid", 1'b1, rspValid)
      if (w) mem[a] = d;
      else `CHK("rspData", srhp_data_t'(mem[a]), rspData)
   endtask
   // Internal processor access; request dropped once granted
   task intOp(input logic w, input srhp_addr_t a, input srhp_data_t d);
      intReq <= 1'b1; intWrite <= w; intAddr <= a; intWdata <= d;
      do @(posedge clk); while (intGrant !== 1'b1);
      intReq <= 1'b0;
      @(posedge clk);
      if (w) mem[a] = d;
      else `CHK("intRdata", srhp_data_t'(mem[a]), intRdata)
      do @(posedge clk); while (intGrant === 1'b1);
   endtask
   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      srhp_addr_t a;
      srhp_addr_t q[$];
      void'($urandom(4765));
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      `CHK("coreResetN", 1'b0, coreResetN)
      `CHK("linkActiveN", 1'b1, bus.linkActiveN)
      do @(posedge clk); while (reqReady !== 1'b1);
      repeat (3) @(posedge clk);
      `CHK("coreResetN", 1'b1, coreResetN)
      `CHK("boardFaultOut", 1'b0, bus.boardFaultOut)
      // Boundary addresses first; internal region kept apart
      for (int i = 0; i < 12; i++) begin
         a = (i == 1) ? 14'h3FFF : srhp_addr_t'($urandom_range(0, 14'h2FFF));
         if (i == 0) a = 14'h0000;
         q.push_back(a);
         hostOp(1'b1, a, srhp_data_t'($urandom));
         hostOp(1'b0, a, 8'h00);
      end
      foreach (q[i]) hostOp(1'b0, q[i], 8'h00);
      // Contention at varied offsets between both requesters
      for (int j = 0; j < 4; j++) begin
         fork
            begin
               repeat ($urandom_range(0, 6)) @(posedge clk);
               intOp(1'b1, srhp_addr_t'(14'h3000 + j),
                     srhp_data_t'($urandom));
            end
            hostOp(1'b0, q[j], 8'h00);
         join
         hostOp(1'b0, srhp_addr_t'(14'h3000 + j), 8'h00);
         intOp(1'b0, q[j], 8'h00);
      end
      for (int v = 1; v >= 0; v--) begin
         monitorAttached <= v[0];
         linkBusy <= v[0];
         repeat (6) @(posedge clk);
         `CHK("handheldSeen", v[0], handheldSeen)
         `CHK("deviceLinkActive", v[0], deviceLinkActive)
         `CHK("linkActiveN", !v[0], bus.linkActiveN)
      end
      // Masked event first, then enabled
      for (int e = 0; e < 2; e++) begin
         intrEnable <= e[0];
         intrEvent <= 1'b1;
         @(posedge clk);
         intrEvent <= 1'b0;
         repeat (14) @(posedge clk);
         `CHK("intrCount", e, intrCount)
      end
      hwError <= 1'b1;
      @(posedge clk);
      hwError <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK("deviceFault", 1'b1, deviceFault)
      `CHK("boardFaultOut", 1'b1, bus.boardFaultOut)
      printVerdict();
   end
endmodule // test_shared_ram_host_port
